// File: logic/asc_ctrl.sv
// Converter sequencing, start-up check and correction control.
// Assumes a modulator bit stream from outside the clock domain.
//
// Functional notes
// R1: First order accepts 9 to 14 bits; cycle about 2^res us.
// R2: Second order stacks two stages; 11 to 15 bits, 2^((res+3)/2) us.
// R3: Count is 2^res times (ratio plus one minus range shift).
// R4: Range shift selects 1/2, 3/4, 7/8 or 15/16 from config.
// R5: Config bit chooses bridge supply or analog supply as reference.
// R6: With analog supply reference, software keeps zero comp on, value 0.
// R7: Sample rate follows from window length per order and resolution.
// R8: Software picks converter resolution one or two bits above output.
// R9: Control starts from reset and sequences from stored configuration.
// R10: Start-up verifies stored configuration against a stored signature.
// R11: Stored registers are parity checked continuously.
// R12: Signature or parity error sets error flag and diagnostic outputs.
// R13: Each result is corrected by a 16-bit polynomial calculation.
// R14: Sensor correction up to third order; temperature up to second.
// R15: Count is unsigned, resolution wide, one per finished conversion.
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
module asc_ctrl (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Converter side
  input  wire logic        mod_bit_i,
  output logic             converter_reference_select_o,
  output logic      [15:0] conv_o,
  // Corrected result and status
  output logic      [15:0] meas_o,
  output logic             meas_vld_o,
  output logic             err_o,
  output logic             irq_o
);

  typedef struct packed {
    asc_pkg::asc_state_t st;
    logic                s0;
    logic                s1;
    logic [3:0]          tk;
    logic                tick;
    logic [15:0]         win;
    logic [16:0]         a1;
    logic [20:0]         a2;
    asc_pkg::asc_cfg_t   cfg;
    logic                run;
    logic [15:0]         sig;
    logic [6:0][15:0]    coef;
    logic [8:0]          par;
    logic [3:0]          idx;
    logic [15:0]         sacc;
    logic [3:0]          scan;
    logic                err;
    logic [2:0]          ist;
    logic [2:0]          imsk;
    logic [15:0]         res;
    logic [15:0]         corr;
    logic                vld;
    logic                ack;
    logic                irq;
    logic                ref_sel;
    logic                pgo;
    logic [31:0]         dat;
  } asc_regs_t;

  asc_regs_t              s;
  asc_regs_t              n;
  asc_pkg::asc_poly_req_t preq;
  logic                   pdone;
  logic [15:0]            py;
  logic                   bus_req;
  logic                   bus_wr;

  // ********************************************************
  // Helpers
  // ********************************************************
  // Word i of the stored set: 0 config, 1..7 coefficients, 8 signature
  function automatic logic [15:0] word_at(asc_regs_t x, logic [3:0] i);
    if (i == 4'h0) return {7'h00, x.cfg};
    if (i == asc_pkg::LAST_P) return x.sig;
    if (i <= asc_pkg::LAST_W) return x.coef[3'(i - 4'h1)];
    return 16'h0000;
  endfunction

  function automatic logic [15:0] merge16(logic [15:0] o,
                                          logic [31:0] d,
                                          logic [3:0]  sel);
    return {sel[1] ? d[15:8] : o[15:8], sel[0] ? d[7:0] : o[7:0]};
  endfunction

  function automatic logic [15:0] rotl(logic [15:0] v);
    return {v[14:0], v[15]};
  endfunction

  assign bus_req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees ack
  assign bus_wr  = bus_req & wb_we_i & s.ack;

  // Corrector request: temperature uses three terms, sensor four [R14]
  assign preq.order = s.cfg.temp_ch ? 2'h2 : 2'h3;
  assign preq.x     = 16'(s.res << (5'h10 - 5'(asc_pkg::eff_res(s.cfg))));
  assign preq.coef  = s.cfg.temp_ch ? {16'h0000, s.coef[6:4]}
                                    : s.coef[3:0];

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    logic [3:0]  r;
    logic [3:0]  e;
    logic [3:0]  k;
    logic [4:0]  sh;
    logic [16:0] a1n;
    logic [20:0] a2n;
    logic [22:0] cval;
    logic [22:0] t;
    logic [22:0] zz;
    logic [22:0] full;
    logic [15:0] w;
    logic [2:0]  ev;
    logic [2:0]  ci;
    logic        pmis;
    n = s;
    r = asc_pkg::eff_res(s.cfg);
    e = asc_pkg::win_exp(s.cfg);
    k = 4'h0;
    sh = 5'h00;
    a1n = 17'h00000;
    a2n = 21'h000000;
    cval = 23'h000000;
    t = 23'h000000;
    zz = 23'h000000;
    full = 23'h000001 << r;
    w = 16'h0000;
    ev = 3'h0;
    ci = 3'(( wb_adr_i - asc_pkg::A_COEF) >> 2);
    n.vld = 1'b0;
    n.pgo = 1'b0;

    // Modulator bit crosses in through two flops
    n.s0 = mod_bit_i;
    n.s1 = s.s0;

    // Microsecond tick, only while converting [R7]
    n.tick = (s.st == asc_pkg::S_CONV) && (s.tk == asc_pkg::TICK_LAST);
    if (s.st == asc_pkg::S_CONV && s.tk != asc_pkg::TICK_LAST) begin
      n.tk = s.tk + 4'h1;
    end else begin
      n.tk = 4'h0;
    end

    // Parity scan walks one stored word per cycle [R11]
    pmis = s.par[s.scan] != ^word_at(s, s.scan);
    n.scan = (s.scan == asc_pkg::LAST_P) ? 4'h0 : s.scan + 4'h1;

    // ******************************************************
    // Sequencer
    // ******************************************************
    unique case (s.st)
      asc_pkg::S_INIT: begin
        // Signature over config and coefficients [R10]
        w = rotl(s.sacc) ^ word_at(s, s.idx);
        n.sacc = w;
        n.idx = s.idx + 4'h1;
        if (s.idx == asc_pkg::LAST_W) begin
          n.idx = 4'h0;
          n.sacc = 16'h0000;
          if (w == s.sig) begin
            n.st = asc_pkg::S_IDLE;
          end else begin
            n.st = asc_pkg::S_ERR; // [R12]
            n.err = 1'b1;
            ev[asc_pkg::IRQ_ERR] = 1'b1;
          end
        end
      end
      asc_pkg::S_IDLE: begin
        if (s.run) begin
          n.st = asc_pkg::S_CONV; // [R9]
        end
      end
      asc_pkg::S_CONV: begin
        if (!s.run) begin
          n.st = asc_pkg::S_IDLE;
          n.win = 16'h0000;
          n.a1 = 17'h00000;
          n.a2 = 21'h000000;
        end else if (s.tick) begin
          // Each one bit weighs two counts over the window [R3]
          a1n = s.a1 + (s.s1 ? 17'h00002 : 17'h00000);
          // Second stage integrates the first [R2]
          a2n = s.a2 + 21'(a1n);
          // Window 2^e ticks: first order e = res [R1] [R7]
          if (s.win >= 16'((17'h00001 << e) - 17'h00001)) begin
            if (s.cfg.order) begin
              sh = 5'({e, 1'b0}) - 5'(r) - 5'h01;
              cval = 23'(a2n >> sh);
            end else begin
              cval = 23'(a1n);
            end
            // Subtract 2^r and add back 2^(r-k) for 1 - 2^-k [R4]
            k = {2'b00, s.cfg.rshift} + 4'h1;
            t = cval + (23'h000001 << (r - k));
            if (t < full) begin
              zz = 23'h000000;
            end else begin
              zz = t - full; // [R3]
            end
            // Result stays an unsigned res-wide word [R15]
            if (zz > full - 23'h000001) begin
              zz = full - 23'h000001;
            end
            n.res = 16'(zz);
            n.win = 16'h0000;
            n.a1 = 17'h00000;
            n.a2 = 21'h000000;
            n.st = asc_pkg::S_CORR;
            n.pgo = 1'b1; // [R13]
            ev[asc_pkg::IRQ_CONV] = 1'b1;
          end else begin
            n.win = s.win + 16'h0001;
            n.a1 = a1n;
            n.a2 = a2n;
          end
        end
      end
      asc_pkg::S_CORR: begin
        if (pdone) begin
          n.corr = py; // [R13]
          n.vld = 1'b1;
          ev[asc_pkg::IRQ_CORR] = 1'b1;
          n.st = s.run ? asc_pkg::S_CONV : asc_pkg::S_IDLE;
        end
      end
      asc_pkg::S_ERR: begin
        n.st = asc_pkg::S_ERR;
      end
      default: begin
        n.st = asc_pkg::S_INIT;
      end
    endcase

    if (pmis) begin
      n.st = asc_pkg::S_ERR; // [R11] [R12]
      n.err = 1'b1;
      ev[asc_pkg::IRQ_ERR] = 1'b1;
    end

    // ******************************************************
    // Register bus
    // ******************************************************
    n.ack = bus_req & ~s.ack;
    n.dat = 32'h00000000;
    if (bus_req & ~s.ack & ~wb_we_i) begin
      case (wb_adr_i)
        asc_pkg::A_CTRL: n.dat = {31'h00000000, s.run};
        asc_pkg::A_CFG:  n.dat = {23'h000000, s.cfg};
        asc_pkg::A_STAT: n.dat = {25'h0000000, s.run, s.err, s.st};
        asc_pkg::A_RES:  n.dat = {16'h0000, s.res};
        asc_pkg::A_CORR: n.dat = {16'h0000, s.corr};
        asc_pkg::A_IST:  n.dat = {29'h00000000, s.ist};
        asc_pkg::A_IMSK: n.dat = {29'h00000000, s.imsk};
        asc_pkg::A_SIG:  n.dat = {16'h0000, s.sig};
        default: begin
          if (wb_adr_i >= asc_pkg::A_COEF &&
              wb_adr_i <= asc_pkg::A_COEF_LAST &&
              wb_adr_i[1:0] == 2'h0) begin
            n.dat = {16'h0000, s.coef[ci]};
          end
        end
      endcase
    end

    if (bus_wr) begin
      case (wb_adr_i)
        asc_pkg::A_CTRL: begin
          if (wb_sel_i[0]) begin
            n.run = wb_dat_i[0];
            // Restart runs the signature check again
            if (wb_dat_i[1]) begin
              n.st = asc_pkg::S_INIT;
              n.idx = 4'h0;
              n.sacc = 16'h0000;
              n.err = 1'b0;
              n.win = 16'h0000;
              n.a1 = 17'h00000;
              n.a2 = 21'h000000;
            end
          end
        end
        asc_pkg::A_CFG: begin
          // Reference select lives in the stored config [R5]
          w = merge16({7'h00, s.cfg}, wb_dat_i, wb_sel_i);
          n.cfg = w[8:0];
          n.par[0] = ^w[8:0];
        end
        asc_pkg::A_IST: begin
          if (wb_sel_i[0]) begin
            n.ist = s.ist & ~wb_dat_i[2:0];
          end
        end
        asc_pkg::A_IMSK: begin
          if (wb_sel_i[0]) begin
            n.imsk = wb_dat_i[2:0];
          end
        end
        asc_pkg::A_SIG: begin
          n.sig = merge16(s.sig, wb_dat_i, wb_sel_i);
          n.par[8] = ^n.sig;
        end
        default: begin
          if (wb_adr_i >= asc_pkg::A_COEF &&
              wb_adr_i <= asc_pkg::A_COEF_LAST &&
              wb_adr_i[1:0] == 2'h0) begin
            n.coef[ci] = merge16(s.coef[ci], wb_dat_i, wb_sel_i);
            n.par[4'(ci) + 4'h1] = ^n.coef[ci];
          end
        end
      endcase
    end

    // Diagnostic value replaces both results while in error [R12]
    if (n.st == asc_pkg::S_ERR) begin
      n.corr = asc_pkg::DIAG;
      n.res = asc_pkg::DIAG;
    end

    // A new event wins over a clear in the same cycle
    n.ist = n.ist | ev;
    n.irq = |(n.ist & n.imsk);
    n.ref_sel = n.cfg.ref_sel; // [R5]
  end

  // ********************************************************
  // State register
  // ********************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.st <= asc_pkg::S_INIT; // [R9]
      s.cfg <= asc_pkg::CFG_RST;
      s.sig <= asc_pkg::SIG_RST;
    end else begin
      s <= n;
    end
  end

  asc_poly u_poly (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .start_i(s.pgo),
    .req_i  (preq),
    .done_o (pdone),
    .y_o    (py)
  );

  assign wb_dat_o                     = s.dat;
  assign wb_ack_o                     = s.ack;
  assign converter_reference_select_o = s.ref_sel;
  assign conv_o                       = s.res;
  assign meas_o                       = s.corr;
  assign meas_vld_o                   = s.vld;
  assign err_o                        = s.err;
  assign irq_o                        = s.irq;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  first_res_a: assert property ( // [R1]
    (s.st == asc_pkg::S_CONV && !s.cfg.order) |->
      asc_pkg::eff_res(s.cfg) inside {[4'h9:4'he]}
  ) else $error("first order resolution out of range");

  second_res_a: assert property ( // [R2]
    (s.st == asc_pkg::S_CONV && s.cfg.order) |->
      asc_pkg::eff_res(s.cfg) inside {[4'hb:4'hf]}
  ) else $error("second order resolution out of range");

  // Cycles since the last tick, saturating, for the spacing check
  logic [3:0] tick_gap_r;

  always_ff @(posedge clk_i) begin
    if (rst_i || s.tick) begin
      tick_gap_r <= 4'h0;
    end else if (tick_gap_r != 4'hf) begin
      tick_gap_r <= tick_gap_r + 4'h1;
    end
  end

  tick_gap_a: assert property ( // [R7]
    s.tick |-> tick_gap_r >= 4'h9
  ) else $error("tick spacing wrong");

  res_width_a: assert property ( // [R15]
    (s.pgo && !err_o) |->
      (conv_o >> asc_pkg::eff_res(s.cfg)) == 16'h0000
  ) else $error("result wider than resolution");

  ref_follow_a: assert property ( // [R5]
    (bus_wr && wb_adr_i == asc_pkg::A_CFG && wb_sel_i[0]) |=>
      converter_reference_select_o == $past(wb_dat_i[7])
  ) else $error("reference select not taken");

  start_init_a: assert property ( // [R9]
    $past(rst_i) |-> s.st == asc_pkg::S_INIT && !err_o
  ) else $error("not in start-up after reset");

  sig_fail_a: assert property ( // [R10]
    (s.st == asc_pkg::S_INIT && s.idx == asc_pkg::LAST_W &&
     (rotl(s.sacc) ^ word_at(s, s.idx)) != s.sig && !bus_wr) |=>
      s.st == asc_pkg::S_ERR && err_o
  ) else $error("signature mismatch missed");

  parity_err_a: assert property ( // [R11]
    (s.par[s.scan] != ^word_at(s, s.scan) && !bus_wr) |=> err_o
  ) else $error("parity fault missed");

  err_diag_a: assert property ( // [R12]
    (s.st == asc_pkg::S_ERR) |-> meas_o == asc_pkg::DIAG &&
                                  conv_o == asc_pkg::DIAG && err_o
  ) else $error("diagnostic value not shown");

  corr_after_a: assert property ( // [R13]
    s.pgo |-> ##[5:6] meas_vld_o
  ) else $error("corrected value late");

  conv_done_c: cover property (s.pgo);
  second_done_c: cover property (s.pgo && s.cfg.order);
  meas_done_c: cover property (meas_vld_o && irq_o);
  error_c: cover property (s.st == asc_pkg::S_ERR);

endmodule

// File: logic/asc_pkg.sv
// Shared constants and types for the converter sequencing block.
// Assumes a 10 MHz system clock and 32-bit classic Wishbone.
package asc_pkg;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_NS   = 100;
  localparam int TICK_NS  = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [3:0] TICK_LAST = 4'(TICK_CYC - 1);

  // ********************************************************
  // Resolution limits per order
  // ********************************************************
  localparam logic [3:0] RES1_MIN = 4'h9;
  localparam logic [3:0] RES1_MAX = 4'he;
  localparam logic [3:0] RES2_MIN = 4'hb;
  localparam logic [3:0] RES2_MAX = 4'hf;

  // ********************************************************
  // Register map (byte addresses)
  // ********************************************************
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_CFG       = 8'h04;
  localparam logic [7:0] A_STAT      = 8'h08;
  localparam logic [7:0] A_RES       = 8'h0c;
  localparam logic [7:0] A_CORR      = 8'h10;
  localparam logic [7:0] A_IST       = 8'h14;
  localparam logic [7:0] A_IMSK      = 8'h18;
  localparam logic [7:0] A_SIG       = 8'h1c;
  localparam logic [7:0] A_COEF      = 8'h20;
  localparam logic [7:0] A_COEF_LAST = 8'h38;

  // ********************************************************
  // Reset values and fixed codes
  // ********************************************************
  localparam logic [8:0]  CFG_RST = 9'h018;
  localparam logic [15:0] SIG_RST = 16'h0c00;
  localparam logic [15:0] DIAG    = 16'hffff;
  localparam logic [3:0]  LAST_W  = 4'h7;
  localparam logic [3:0]  LAST_P  = 4'h8;
  localparam int IRQ_CONV = 0;
  localparam int IRQ_CORR = 1;
  localparam int IRQ_ERR  = 2;

  typedef enum logic [4:0] {
    S_INIT = 5'h01,
    S_IDLE = 5'h02,
    S_CONV = 5'h04,
    S_CORR = 5'h08,
    S_ERR  = 5'h10
  } asc_state_t;

  typedef struct packed {
    logic       temp_ch;
    logic       ref_sel;
    logic [1:0] rshift;
    logic [3:0] res;
    logic       order;
  } asc_cfg_t;

  typedef struct packed {
    logic [1:0]       order;
    logic [15:0]      x;
    logic [3:0][15:0] coef;
  } asc_poly_req_t;

  // Resolution clamped into the legal set of the chosen order
  function automatic logic [3:0] eff_res(asc_cfg_t c);
    logic [3:0] lo;
    logic [3:0] hi;
    lo = c.order ? RES2_MIN : RES1_MIN;
    hi = c.order ? RES2_MAX : RES1_MAX;
    if (c.res < lo) return lo;
    if (c.res > hi) return hi;
    return c.res;
  endfunction

  // Window length exponent in microsecond ticks
  function automatic logic [3:0] win_exp(asc_cfg_t c);
    logic [4:0] r;
    r = {1'b0, eff_res(c)};
    if (c.order) return 4'((r + 5'h3) >> 1);
    return r[3:0];
  endfunction

endpackage

// File: logic/asc_poly.sv
// Horner evaluator for the signed 16-bit correction polynomial.
// Assumes start_i is a one-cycle pulse from the sequencer.
`timescale 1ns/10ps
module asc_poly (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Request
  input  wire logic                  start_i,
  input  wire asc_pkg::asc_poly_req_t req_i,
  // Answer
  output logic                       done_o,
  output logic [15:0]                y_o
);

  typedef struct packed {
    logic                   busy;
    logic [1:0]             k;
    logic [15:0]            acc;
    logic                   done;
    logic [15:0]            y;
    asc_pkg::asc_poly_req_t rq;
  } asc_poly_st_t;

  asc_poly_st_t s;
  asc_poly_st_t n;

  always_comb begin
    logic signed [32:0] pr;
    logic signed [17:0] sum;
    n = s;
    pr = '0;
    sum = '0;
    n.done = 1'b0;
    if (start_i) begin
      n.rq = req_i;
      n.k = req_i.order;
      n.acc = req_i.coef[req_i.order];
      n.busy = 1'b1;
    end else if (s.busy) begin
      if (s.k == 2'h0) begin
        n.busy = 1'b0;
        n.done = 1'b1;
        n.y = s.acc;
      end else begin
        // Fixed 16-bit fractional step, saturated [R13]
        pr = $signed(s.acc) * $signed({1'b0, s.rq.x});
        // Keep the product's sign when widening it for the sum
        sum = 18'($signed(s.rq.coef[s.k - 2'h1])) +
              18'($signed(pr[32:16]));
        if (sum > 18'sh07fff) begin
          n.acc = 16'h7fff;
        end else if (sum < -18'sh08000) begin
          n.acc = 16'h8000;
        end else begin
          n.acc = sum[15:0];
        end
        n.k = s.k - 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign done_o = s.done;
  assign y_o    = s.y;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  poly_latency_a: assert property ( // [R13]
    start_i |-> ##[4:5] done_o
  ) else $error("poly answer late");

  temp_order_a: assert property ( // [R14]
    (start_i && req_i.order == 2'h2) |-> !done_o[*4] ##1 done_o
  ) else $error("second order timing wrong");

endmodule

// File: tb/test_asc_ctrl.sv
// Self-checking bench for the converter sequencing and control block.
// Assumes asc_ctrl answers each Wishbone request one cycle after it.
`timescale 1ns/10ps
module test_asc_ctrl;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        mod_bit_i;
  logic        ref_sel;
  logic [15:0] conv_o;
  logic [15:0] meas_o;
  logic        meas_vld_o;
  logic        err_o;
  logic        irq_o;
  logic        tog;
  logic        lvl;
  logic [31:0] rd;
  logic [15:0] cfg;
  logic [15:0] c0;
  logic [15:0] c1;
  logic [15:0] sg;
  logic [1:0]  sh;
  int          dt;
  int          tc = 0;
  int          cyc = 0;
  int          err_count = 0;
  int          checks = 0;

  asc_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mod_bit_i(mod_bit_i),
    .converter_reference_select_o(ref_sel), .conv_o(conv_o),
    .meas_o(meas_o), .meas_vld_o(meas_vld_o), .err_o(err_o),
    .irq_o(irq_o));

  // **********************************************************
  // Clock, modulator stream and timeout
  // **********************************************************
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Toggling once per 1 us tick gives exactly half ones in an even window
  always @(posedge clk_i) begin
    tc <= (tc == 19) ? 0 : tc + 1;
    mod_bit_i <= tog ? (tc < 10) : lvl;
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      err_count++;
      $display("mismatch at %0t: run timed out", $time);
      complete_run();
    end
  end

  // **********************************************************
  // Model and tasks
  // **********************************************************
  // Signature over config and the seven coefficients (only 0 and 4 used)
  function automatic logic [15:0] sig_of(logic [15:0] f, logic [15:0] a,
                                         logic [15:0] b);
    logic [15:0] s;
    logic [15:0] w [8];
    w = '{f, a, 16'h0000, 16'h0000, 16'h0000, b, 16'h0000, 16'h0000};
    s = 16'h0000;
    for (int i = 0; i < 8; i++) s = {s[14:0], s[15]} ^ w[i];
    return s;
  endfunction

  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) begin
      err_count++;
      $display("mismatch at %0t: no bus ack", $time);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // Bounded wait for the corrected result of a conversion
  task automatic run_conv();
    dt = 0;
    while (meas_vld_o !== 1'b1 && dt < 40000) begin
      @(posedge clk_i);
      dt++;
    end
  endtask

  task automatic complete_run();
    $display("counts: %0d checks, %0d mismatches", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // **********************************************************
  // Tests
  // **********************************************************
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    mod_bit_i = 1'b0;
    tog = 1'b0;
    lvl = 1'b0;
    void'($urandom(43215));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk(ref_sel, 1'b0, "ref select reset");
    chk(err_o, 1'b0, "err after start-up");
    bus(1'b0, asc_pkg::A_CFG, 16'h0000);
    chk(rd, 32'h0000_0018, "cfg reset");
    bus(1'b0, asc_pkg::A_SIG, 16'h0000);
    chk(rd, {16'h0000, sig_of(16'h0018, 16'h0000, 16'h0000)}, "sig");
    bus(1'b0, asc_pkg::A_STAT, 16'h0000);
    chk(rd[4:0], 5'h02, "idle after check");
    bus(1'b0, 8'h40, 16'h0000);
    chk(rd, 32'h0000_0000, "unmapped read");
    bus(1'b1, asc_pkg::A_IMSK, 16'h0001);
    bus(1'b0, asc_pkg::A_IMSK, 16'h0000);
    chk(rd, 32'h0000_0001, "mask readback");
    $display("test reset and map done");

    // First order, resolution 4 clamps to 9, random range shift
    sh = 2'($urandom_range(3));
    c0 = 16'($urandom_range(32767));
    cfg = {8'h00, 1'b1, sh, 4'h4, 1'b0};
    bus(1'b1, asc_pkg::A_COEF, c0);
    bus(1'b1, asc_pkg::A_CFG, cfg);
    chk(ref_sel, 1'b1, "analog supply reference");
    tog <= 1'b1;
    bus(1'b1, asc_pkg::A_CTRL, 16'h0001);
    run_conv();
    chk(dt >= 5115 && dt <= 5160, 1'b1, "first order time");
    chk(conv_o, 16'h0001 << (8 - sh), "first order count");
    chk(meas_o, c0, "sensor correction");
    chk(irq_o, 1'b1, "conversion irq");
    bus(1'b1, asc_pkg::A_IST, 16'h0001);
    @(posedge clk_i);
    chk(irq_o, 1'b0, "irq cleared");
    bus(1'b1, asc_pkg::A_CTRL, 16'h0000);
    tog <= 1'b0;
    $display("test first order done");

    // Second order 11 bit, temperature channel, full-scale input
    lvl <= 1'b1;
    c1 = 16'($urandom_range(32767));
    cfg = 16'h0117;
    bus(1'b1, 8'h30, c1);
    bus(1'b1, asc_pkg::A_CFG, cfg);
    bus(1'b1, asc_pkg::A_CTRL, 16'h0001);
    run_conv();
    chk(dt >= 1275 && dt <= 1320, 1'b1, "second order time");
    chk(conv_o, 16'h07ff, "second order count");
    chk(meas_o, c1, "temperature correction");
    bus(1'b1, asc_pkg::A_CTRL, 16'h0000);
    $display("test second order done");

    // Wrong signature, then the right one
    sg = sig_of(cfg, c0, c1);
    bus(1'b1, asc_pkg::A_IMSK, 16'h0004);
    bus(1'b1, asc_pkg::A_SIG, sg ^ 16'h0001);
    bus(1'b1, asc_pkg::A_CTRL, 16'h0002);
    repeat (12) @(posedge clk_i);
    chk(err_o, 1'b1, "error flag");
    chk(conv_o, asc_pkg::DIAG, "diag count");
    chk(meas_o, asc_pkg::DIAG, "diag result");
    chk(irq_o, 1'b1, "error irq");
    bus(1'b0, asc_pkg::A_STAT, 16'h0000);
    chk(rd[5:0], 6'h30, "error state");
    bus(1'b1, asc_pkg::A_SIG, sg);
    bus(1'b1, asc_pkg::A_CTRL, 16'h0002);
    repeat (12) @(posedge clk_i);
    chk(err_o, 1'b0, "signature match");
    $display("test signature done");
    complete_run();
  end
endmodule
